// ==== design/acc_consts.vh ====
// Purpose: Shared constants of the converter control block.
// Assumes: Included by every design file of the block.
// Notes: Offsets are register indices on the 8-bit register port.
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
// ----------------------------------------
// Register offsets.
// ----------------------------------------
`define ACC_OFF_CTRL 3'h0
`define ACC_OFF_ANS 3'h1
`define ACC_OFF_RES 3'h2
`define ACC_OFF_IFLG 3'h3
`define ACC_OFF_IEN 3'h4
// ----------------------------------------
// Reset values.
// ----------------------------------------
`define ACC_CS_RST 2'h3
`define ACC_CHS_RST 4'hF
`define ACC_ANS_RST 8'hFF
// ----------------------------------------
// Field positions.
// ----------------------------------------
`define ACC_CS_HI 7
`define ACC_CS_LO 6
`define ACC_CH_HI 5
`define ACC_CH_LO 2
`define ACC_GO 1
`define ACC_PWR 0
`define ACC_SRC_HI 7
`define ACC_SRC_LO 4
`define ACC_GLB 0
// ----------------------------------------
// Clock select codes and timing counts.
// ----------------------------------------
`define ACC_CS_DIV16 2'h0
`define ACC_CS_DIV8 2'h1
`define ACC_CS_DIV4 2'h2
`define ACC_CS_INT4 2'h3
`define ACC_INSTR_LAST 2'h3
`define ACC_LIM_DIV16 2'h3
`define ACC_LIM_DIV8 2'h1
`define ACC_LIM_DIV4 2'h0
`define ACC_LIM_INT4 2'h3
`define ACC_TAD_CLEAR 4'h3
`define ACC_MARK_MSB 8'h80
`define ACC_MARK_LSB 8'h01
`endif

// ==== design/acc_sar.v ====
// Purpose: Successive approximation sequencer, thirteen periods per conversion.
// Assumes: cmp_i is high when the input lies above the trial code.
// Notes: Dropping run_i stops the sequence and keeps a partial result.
`timescale 1ns/1ns
`include "acc_consts.vh"
module acc_sar (
    input wire clk_i,
    input wire rst_b_i,
    input wire run_i,
    input wire tad_i,
    input wire cmp_i,
    output reg done_o,
    output reg sample_o,
    output reg [7:0] res_o,
    output reg [7:0] trial_o
);
    localparam S_IDLE = 4'h1;
    localparam S_SAMP = 4'h2;
    localparam S_CONV = 4'h4;
    localparam S_LAST = 4'h8;
    reg [3:0] st_q;
    reg [3:0] tad_q;
    reg [7:0] mark_q;
    wire [7:0] kept;

    assign kept = res_o | (cmp_i ? mark_q : 8'h00);

    // four sampling, eight bit, one final period
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            st_q <= S_IDLE;
            tad_q <= 4'h0;
            mark_q <= 8'h00;
            done_o <= 1'b0;
            sample_o <= 1'b0;
            res_o <= 8'h00;
            trial_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            if (!run_i) begin
                st_q <= S_IDLE;
                tad_q <= 4'h0;
                sample_o <= 1'b0;
            end else begin
                case (st_q)
                    S_IDLE: begin
                        // A done pulse still in flight must not restart.
                        if (!done_o) begin
                            st_q <= S_SAMP;
                            sample_o <= 1'b1;
                            tad_q <= 4'h0;
                        end
                    end
                    S_SAMP: begin
                        if (tad_i) begin
                            tad_q <= tad_q + 4'h1;
                            if (tad_q == `ACC_TAD_CLEAR) begin
                                res_o <= 8'h00;
                                mark_q <= `ACC_MARK_MSB;
                                trial_o <= `ACC_MARK_MSB;
                                sample_o <= 1'b0;
                                st_q <= S_CONV;
                            end
                        end
                    end
                    S_CONV: begin
                        if (tad_i) begin
                            res_o <= kept;
                            mark_q <= mark_q >> 1;
                            trial_o <= kept | (mark_q >> 1);
                            if (mark_q == `ACC_MARK_LSB) begin
                                st_q <= S_LAST;
                            end
                        end
                    end
                    S_LAST: begin
                        if (tad_i) begin
                            done_o <= 1'b1;
                            st_q <= S_IDLE;
                        end
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule // acc_sar

// ==== design/acc_tad_div.v ====
// Purpose: Makes the converter clock period enable from the instruction clock, or from the internal oscillator for code 11.
// Assumes: clk_i is the main oscillator; four of its cycles make one instruction.
// Notes: The count restarts whenever run_i is low, but the instruction phase runs free, so the first period can be short.
`timescale 1ns/1ns
`include "acc_consts.vh"
module acc_tad_div (
    input wire clk_i,
    input wire rst_b_i,
    input wire run_i,
    input wire [1:0] sel_i,
    input wire osc_tick_i,
    output reg tad_o
);
    reg [1:0] ic_q;
    reg [1:0] cnt_q;
    reg [1:0] lim;
    wire instr_tick;
    wire evt;

    assign instr_tick = (ic_q == `ACC_INSTR_LAST);
    assign evt = (sel_i == `ACC_CS_INT4) ? osc_tick_i : instr_tick;

    always @* begin
        case (sel_i)
            `ACC_CS_DIV16: lim = `ACC_LIM_DIV16;
            `ACC_CS_DIV8: lim = `ACC_LIM_DIV8;
            `ACC_CS_DIV4: lim = `ACC_LIM_DIV4;
            default: lim = `ACC_LIM_INT4;
        endcase
    end

    // Free instruction phase counter and the period counter.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ic_q <= 2'h0;
            cnt_q <= 2'h0;
            tad_o <= 1'b0;
        end else begin
            ic_q <= ic_q + 2'h1;
            tad_o <= 1'b0;
            if (!run_i) begin
                cnt_q <= 2'h0;
            end else if (evt) begin
                if (cnt_q == lim) begin
                    cnt_q <= 2'h0;
                    tad_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
endmodule // acc_tad_div

// ==== design/acc_top.v ====
// Purpose: Control of an 8-bit converter plus its interrupt flag registers.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes: Sleep is a level from the core; conversions cannot run during it.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`include "acc_consts.vh"

// What this block does
// - A conversion always lasts thirteen converter clock periods.
// - Clock choices are oscillator over 16, 8, 4, or internal over 4.
// - Select code 00 is /16, 01 /8, 10 /4, 11 internal /4.
// - A clock select change applies from the next conversion only.
// - Sleep returns the clock select field to its default.
// - The converter clock is the instruction clock divided down, or the internal oscillator over 4 for code 11.
// - Every reset sets the analog pin select field to all ones.
// - An analog pin has its digital output driver switched off.
// - Analog pin selection works whatever the power-on bit is.
// - A channel change waits until the running conversion ends.
// - Sleep returns the channel field to its default.
// - Start bit begins a conversion; completion clears it, sets done flag.
// - Clearing the start bit mid conversion stops it, keeping partial result.
// - An aborted conversion never sets the done flag.
// - Sleep clears the start bit and stops any conversion.
// - Setting the start bit is ignored while power-on is clear.
// - Done flag is bit 7, sticky until software clears it.
// - Enable bit 7 gates the converter interrupt.
// - Flags 6, 5, 4 are comparator, timer, port change, with enables.
// - Global enable bit 0 chooses vectoring over inline wake.
// - Wake-reset bit 0 makes a wake from Sleep a reset.
module acc_top (
    input wire clk_i,
    input wire rst_b_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire sleep_i,
    input wire comp_i,
    input wire internal_oscillator_i,
    input wire cmp_chg_i,
    input wire tmr_ovf_i,
    input wire port_chg_i,
    input wire [7:0] pin_oe_req_i,
    output reg [7:0] rdata_o,
    output wire [7:0] ana_en_o,
    output reg [7:0] pin_oe_o,
    output wire [3:0] chan_o,
    output wire adc_pwr_o,
    output wire sample_o,
    output wire [7:0] trial_o,
    output reg irq_o,
    output reg vector_o,
    output reg wake_o,
    output reg wake_reset_o
);

    // ----------------------------------------
    // Storage.
    // ----------------------------------------
    reg [1:0] cs_q;
    reg [3:0] chs_q;
    reg go_q;
    reg pwr_q;
    reg [7:0] ans_q;
    reg [3:0] chan_q;
    reg [1:0] cs_run_q;
    reg [3:0] flg_q;
    reg gie_q;
    reg [3:0] ien_q;
    reg wur_q;
    reg [1:0] sy1_q;
    reg [1:0] sy2_q;
    reg [1:0] sy3_q;
    reg [1:0] lvl_q;
    reg osc_prev_q;

    wire wr_ctrl;
    wire wr_ans;
    wire wr_iflg;
    wire wr_ien;
    wire start;
    wire abort;
    wire tad;
    wire sar_done;
    wire adc_done;
    wire osc_tick;
    wire pend;
    wire [7:0] res;
    wire [1:0] async_in;
    wire [3:0] flg_src;
    wire [3:0] flg_keep;

    // ----------------------------------------
    // Input synchronisers.
    // ----------------------------------------

    // The comparator and the internal oscillator come from outside this clock.
    assign async_in = {internal_oscillator_i, comp_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            // A level counts only once the second and third stages agree.
            always @(posedge clk_i) begin
                if (!rst_b_i) begin
                    sy1_q[gi] <= 1'b0;
                    sy2_q[gi] <= 1'b0;
                    sy3_q[gi] <= 1'b0;
                    lvl_q[gi] <= 1'b0;
                end else begin
                    sy1_q[gi] <= async_in[gi];
                    sy2_q[gi] <= sy1_q[gi];
                    sy3_q[gi] <= sy2_q[gi];
                    if (sy2_q[gi] == sy3_q[gi]) begin
                        lvl_q[gi] <= sy3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // Rising edges of the filtered internal oscillator level.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            osc_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= lvl_q[1];
        end
    end

    // The internal oscillator must run well below clk_i to be seen at all.
    assign osc_tick = lvl_q[1] & ~osc_prev_q;

    // ----------------------------------------
    // Write decode and conversion requests.
    // ----------------------------------------
    assign wr_ctrl = wr_i & (addr_i == `ACC_OFF_CTRL);
    assign wr_ans = wr_i & (addr_i == `ACC_OFF_ANS);
    assign wr_iflg = wr_i & (addr_i == `ACC_OFF_IFLG);
    assign wr_ien = wr_i & (addr_i == `ACC_OFF_IEN);

    assign start = wr_ctrl & wdata_i[`ACC_GO] & wdata_i[`ACC_PWR] & ~go_q & ~sleep_i;

    // clearing the bit aborts
    // Switching power off mid conversion also stops it, with no done flag.
    assign abort = go_q & wr_ctrl & (~wdata_i[`ACC_GO] | ~wdata_i[`ACC_PWR]);

    assign adc_done = sar_done & go_q;

    // ----------------------------------------
    // Control register.
    // ----------------------------------------

    // Clock select, channel, start and power-on bits.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cs_q <= `ACC_CS_RST;
            chs_q <= `ACC_CHS_RST;
            go_q <= 1'b0;
            pwr_q <= 1'b0;
        end else if (sleep_i) begin
            cs_q <= `ACC_CS_RST;
            chs_q <= `ACC_CHS_RST;
            go_q <= 1'b0;
            pwr_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                cs_q <= wdata_i[`ACC_CS_HI:`ACC_CS_LO];
                chs_q <= wdata_i[`ACC_CH_HI:`ACC_CH_LO];
                pwr_q <= wdata_i[`ACC_PWR];
            end
            if (start) begin
                go_q <= 1'b1;
            end else if (sar_done | abort) begin
                go_q <= 1'b0;
            end
        end
    end

    // clock latched at start
    // The readable field may change freely; the running divisor does not.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cs_run_q <= `ACC_CS_RST;
        end else if (start) begin
            cs_run_q <= wdata_i[`ACC_CS_HI:`ACC_CS_LO];
        end
    end

    // channel held while busy
    // Between conversions the analog mux follows the written field at once.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            chan_q <= `ACC_CHS_RST;
        end else if (sleep_i) begin
            chan_q <= `ACC_CHS_RST;
        end else if (!go_q) begin
            chan_q <= wr_ctrl ? wdata_i[`ACC_CH_HI:`ACC_CH_LO] : chs_q;
        end
    end

    // ----------------------------------------
    // Analog pin selection.
    // ----------------------------------------

    // independent of power-on
    // Sleep leaves this field untouched.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ans_q <= `ACC_ANS_RST;
        end else if (wr_ans) begin
            ans_q <= wdata_i;
        end
    end

    // analog pins lose driver
    // One cycle of lag after a write is harmless next to pin settling.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            pin_oe_o <= 8'h00;
        end else begin
            pin_oe_o <= pin_oe_req_i & ~ans_q;
        end
    end

    // ----------------------------------------
    // Converter clock and sequencer.
    // ----------------------------------------

    acc_tad_div u_div (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(go_q),
        .sel_i(cs_run_q),
        .osc_tick_i(osc_tick),
        .tad_o(tad)
    );

    acc_sar u_sar (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(go_q),
        .tad_i(tad),
        .cmp_i(lvl_q[0]),
        .done_o(sar_done),
        .sample_o(sample_o),
        .res_o(res),
        .trial_o(trial_o)
    );

    // ----------------------------------------
    // Interrupt flags and enables.
    // ----------------------------------------

    assign flg_src = {adc_done, cmp_chg_i, tmr_ovf_i, port_chg_i};
    assign flg_keep = wr_iflg ? wdata_i[`ACC_SRC_HI:`ACC_SRC_LO] : flg_q;

    // flags ignore enables
    // A source event in the cycle of a clearing write wins over the write.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            flg_q <= 4'h0;
            gie_q <= 1'b0;
        end else begin
            flg_q <= flg_keep | flg_src;
            if (wr_iflg) begin
                gie_q <= wdata_i[`ACC_GLB];
            end
        end
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            ien_q <= 4'h0;
            wur_q <= 1'b0;
        end else if (wr_ien) begin
            ien_q <= wdata_i[`ACC_SRC_HI:`ACC_SRC_LO];
            wur_q <= wdata_i[`ACC_GLB];
        end
    end

    assign pend = |(flg_q & ien_q);

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
            vector_o <= 1'b0;
            wake_o <= 1'b0;
            wake_reset_o <= 1'b0;
        end else begin
            irq_o <= pend;
            vector_o <= pend & gie_q & ~(sleep_i & wur_q);
            wake_o <= pend & sleep_i;
            wake_reset_o <= pend & sleep_i & wur_q;
        end
    end

    // ----------------------------------------
    // Read port.
    // ----------------------------------------

    // unused bits read zero
    // Data stand only in the cycle after the strobe; unmapped reads give zero.
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `ACC_OFF_CTRL: rdata_o <= {cs_q, chs_q, go_q, pwr_q};
                `ACC_OFF_ANS: rdata_o <= ans_q;
                `ACC_OFF_RES: rdata_o <= res;
                `ACC_OFF_IFLG: rdata_o <= {flg_q, 3'h0, gie_q};
                `ACC_OFF_IEN: rdata_o <= {ien_q, 3'h0, wur_q};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------
    // Flop-fed outputs.
    // ----------------------------------------

    // These are register bits passed out unchanged.
    assign ana_en_o = ans_q;
    assign chan_o = chan_q;
    assign adc_pwr_o = pwr_q;

endmodule // acc_top

// ==== verif/acc_analog_model.sv ====
// Purpose: Analog side of the converter: input comparator and internal oscillator.
// Assumes: The selected pin carries vin_i; the oscillator runs free.
// Notes: The comparator answers at once; the block must synchronise it.
`timescale 1ns/1ns
module acc_analog_model #(
    parameter int OSC_NS = 300
) (
    input wire [7:0] trial_i,
    input wire [7:0] vin_i,
    output logic comp_o,
    output logic internal_oscillator_o
);
    // At or above the trial code keeps the bit, so a whole conversion lands on vin_i.
    assign comp_o = (vin_i >= trial_i);
    // The oscillator never stops; a half period under two clocks would be filtered away.
    initial begin
        internal_oscillator_o = 1'b0;
        forever #(OSC_NS / 2) internal_oscillator_o = ~internal_oscillator_o;
    end
endmodule // acc_analog_model

// ==== verif/acc_checker.sv ====
// Purpose: Port-level assertions for the converter control block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Sees only the top module's ports and is attached by bind.
`timescale 1ns/1ns
module acc_checker (
    input wire clk_i,
    input wire rst_b_i,
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire sleep_i,
    input wire [7:0] rdata_o,
    input wire [7:0] ana_en_o,
    input wire [7:0] pin_oe_o,
    input wire [3:0] chan_o,
    input wire adc_pwr_o,
    input wire sample_o,
    input wire irq_o,
    input wire vector_o,
    input wire wake_o,
    input wire wake_reset_o
);
    // ---------------------------------
    // Properties
    // ---------------------------------
    // The enable lags one cycle, so a freshly selected pin is judged a cycle late.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_oe_vs_analog: assert property ((pin_oe_o & ana_en_o & $past(ana_en_o)) == 8'h00)
        else $error("digital driver enabled on analog pin");
    a_ans_reset: assert property ($past(!rst_b_i) |-> ana_en_o == 8'hFF)
        else $error("analog pin select not all ones after reset");
    a_ans_write: assert property (wr_i && addr_i == 3'h1 && !sleep_i |=> ana_en_o == $past(wdata_i))
        else $error("analog pin select write lost");
    a_unmapped_zero: assert property (rd_i && addr_i > 3'h4 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_chan_hold: assert property (sample_o [*3] ##0 !sleep_i |-> $stable(chan_o))
        else $error("channel moved during conversion");
    a_sleep_off: assert property (sleep_i [*4] |-> chan_o == 4'hF && !adc_pwr_o && !sample_o)
        else $error("converter still active in sleep");
    a_sample_pwr: assert property (sample_o |-> $past(adc_pwr_o) || $past(adc_pwr_o, 2))
        else $error("sampling without power bit");
    a_wake_sleep: assert property (wake_o |-> $past(sleep_i) || $past(sleep_i, 2))
        else $error("wake outside sleep");
    a_wake_reset: assert property (wake_reset_o |-> wake_o)
        else $error("wake reset without wake");
    a_vector_irq: assert property (vector_o |-> irq_o && !wake_reset_o)
        else $error("vector without request or during wake reset");
endmodule // acc_checker

bind acc_top acc_checker acc_checker_inst (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .sleep_i, .rdata_o, .ana_en_o, .pin_oe_o, .chan_o, .adc_pwr_o, .sample_o, .irq_o,
    .vector_o, .wake_o, .wake_reset_o);

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the converter control block.
// Assumes: Register port with read data in the cycle after the strobe.
// Notes: Conversion lengths are checked with slack for polling and pipeline.
`timescale 1ns/1ns
module tb_top;
    // Each half period spans three clocks, so the input filter never drops a level.
    localparam int OSC_NS = 300;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [2:0] addr_i = 3'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [2:0] ev = 3'h0;
    logic [7:0] pin_oe_req_i = 8'h00;
    logic [7:0] vin = 8'h00;
    wire comp_w, internal_oscillator_w, adc_pwr_o, sample_o, irq_o, vector_o, wake_o, wake_reset_o;
    wire [7:0] rdata_o, ana_en_o, pin_oe_o, trial_o;
    wire [3:0] chan_o;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;

    acc_top acc_top_inst (.clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .sleep_i,
        .comp_i(comp_w), .internal_oscillator_i(internal_oscillator_w), .cmp_chg_i(ev[2]), .tmr_ovf_i(ev[1]),
        .port_chg_i(ev[0]), .pin_oe_req_i, .rdata_o, .ana_en_o, .pin_oe_o, .chan_o,
        .adc_pwr_o, .sample_o, .trial_o, .irq_o, .vector_o, .wake_o, .wake_reset_o);
    acc_analog_model #(.OSC_NS(OSC_NS)) acc_analog_model_inst (.trial_i(trial_o),
        .vin_i(vin), .comp_o(comp_w), .internal_oscillator_o(internal_oscillator_w));

    // ---------------------------------
    // Clock, tasks and expectations
    // ---------------------------------
    // The clock and a cycle count used to time conversions.
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, exp, d);
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Cycles of a whole conversion: thirteen periods of the selected clock.
    function automatic int exp_len(input logic [1:0] s);
        return (s == 2'h3) ? 13 * 4 * OSC_NS / 50 : 13 * (16 >> s);
    endfunction
    // One conversion with a select rewrite in mid-run; returns its length in cycles.
    task automatic conv(input logic [1:0] sel, input logic [3:0] ch, input logic [1:0] sel2,
        input logic [3:0] ch2, output int len);
        logic [7:0] d;
        int t0;
        vin = 8'($urandom);
        wr(3'h0, {sel, ch, 2'b01});
        repeat (20) @(posedge clk_i);
        t0 = cyc;
        wr(3'h0, {sel, ch, 2'b11});
        repeat (20) @(posedge clk_i);
        wr(3'h0, {sel2, ch2, 2'b11});
        @(negedge clk_i);
        chk("channel held", ch, chan_o);
        d = 8'h02;
        for (int i = 0; i < 400 && d[1]; i++) rd(3'h0, d);
        len = cyc - t0;
        chk("go cleared", 1'b0, d[1]);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("channel after", ch2, chan_o);
    endtask

    // ---------------------------------
    // Scenarios
    // ---------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] en;
        logic [7:0] g;
        logic [2:0] evv;
        logic sl;
        int len;
        void'($urandom(83));
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // Unmapped writes first, then every register must still show its reset value.
        for (int a = 5; a < 8; a++) wr(a[2:0], 8'hFF);
        for (int a = 0; a < 8; a++) rdc(a[2:0], a == 0 ? 8'hFC : a == 1 ? 8'hFF : 8'h00, "reset");
        // Every clock code, with a new select written mid-run; code 11 is the low-speed choice.
        wr(3'h4, 8'h80);
        for (int s = 0; s < 4; s++) begin
            conv(s[1:0], s[3:0], 2'($urandom), 4'($urandom & 7), len);
            chk("length", 1'b1, len >= exp_len(s[1:0]) && len <= exp_len(s[1:0]) * 9 / 8 + 16);
            // Fosc/4 gives a period below the accurate range, so its code is not checked.
            if (s != 2) rdc(3'h2, vin, "result");
            rd(3'h3, d);
            chk("done flag", 1'b1, d[7]);
            chk("done irq", 1'b1, irq_o);
            wr(3'h3, 8'h00);
            rdc(3'h3, 8'h00, "flag cleared");
        end
        // A start without the power bit is dropped.
        wr(3'h0, 8'hFC);
        wr(3'h0, 8'hFE);
        rdc(3'h0, 8'hFC, "start unpowered");
        // Abort by clearing the start bit.
        wr(3'h0, 8'h01);
        wr(3'h0, 8'h03);
        repeat (100) @(posedge clk_i);
        wr(3'h0, 8'h01);
        rd(3'h0, d);
        chk("abort go", 1'b0, d[1]);
        repeat (300) @(posedge clk_i);
        rdc(3'h3, 8'h00, "abort flag");
        // Sleep in mid-conversion.
        wr(3'h0, 8'h55);
        wr(3'h0, 8'h57);
        repeat (30) @(posedge clk_i);
        sleep_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rdc(3'h0, 8'hFC, "sleep control");
        @(posedge clk_i);
        sleep_i <= 1'b0;
        repeat (250) @(posedge clk_i);
        rdc(3'h3, 8'h00, "sleep flag");
        // Analog pin selection against requested drivers, power bit on and off.
        for (int i = 0; i < 6; i++) begin
            wr(3'h0, {7'h7E, i[0]});
            d = 8'($urandom);
            wr(3'h1, d);
            pin_oe_req_i <= 8'($urandom);
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chk("analog pins", d, ana_en_o);
            chk("pin enables", pin_oe_req_i & ~d, pin_oe_o);
        end
        // Interrupt sources against random enables, global enable and sleep.
        for (int i = 0; i < 12; i++) begin
            en = 8'($urandom);
            g = 8'($urandom);
            evv = 3'($urandom);
            sl = 1'($urandom);
            wr(3'h4, en);
            wr(3'h3, {4'h0, g[3:0]});
            ev <= evv;
            sleep_i <= sl;
            @(posedge clk_i);
            ev <= 3'h0;
            repeat (3) @(posedge clk_i);
            @(negedge clk_i);
            chk("irq", |({1'b0, evv} & en[7:4]), irq_o);
            chk("vector", |({1'b0, evv} & en[7:4]) & g[0] & ~(sl & en[0]), vector_o);
            chk("wake", |({1'b0, evv} & en[7:4]) & sl, wake_o);
            chk("wake reset", |({1'b0, evv} & en[7:4]) & sl & en[0], wake_reset_o);
            rdc(3'h3, {1'b0, evv, 3'h0, g[0]}, "flags");
            rdc(3'h4, en & 8'hF1, "enables");
            @(posedge clk_i);
            sleep_i <= 1'b0;
        end
        end_of_test;
    end

    // A hung handshake ends the run as a failure.
    initial begin
        #(50 * 40000);
        miscompares++;
        end_of_test;
    end
endmodule // tb_top
